// ---- pkg/apdc_pkg.sv ----
package apdc_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W     = 20;    // Full word address
   localparam int HALF_W     = 10;    // One multiplexed half
   localparam int DATA_W     = 9;     // Eight shared bits plus the ninth
   localparam int TMR_W      = 12;    // Width of the state timer
   localparam int STALE_W    = 20;    // Width of the refresh watchdog

   // ---------------------------------------------------------------
   // Times as printed, and derived cycle counts
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_RP_NS       = 70;       // Row strobe precharge
   localparam int T_RAS_NS      = 100;      // Row strobe pulse width
   localparam int T_RCD_NS      = 25;       // Row to column strobe delay
   localparam int T_CAS_NS      = 25;       // Column strobe pulse width
   localparam int T_CAC_NS      = 25;       // Access time from column strobe
   localparam int T_CSR_NS      = 10;       // Column setup before row strobe
   localparam int T_POWERUP_US  = 100;      // Pause after power-up
   localparam int T_REF_MS      = 8;        // Refresh period for all rows
   localparam int REF_ROWS      = 512;      // Rows refreshed per period
   localparam int WAKE_COUNT    = 8;        // Row cycles of the wake-up

   // Least times round up
   localparam logic [TMR_W-1:0] RP_CYC  =
      TMR_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] RAS_CYC =
      TMR_W'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] RCD_CYC =
      TMR_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] CSR_CYC =
      TMR_W'((T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Column strobe low long enough for the pulse and one sample cycle
   localparam int CAS_RAW = (T_CAS_NS > T_CAC_NS) ? T_CAS_NS : T_CAC_NS;
   localparam logic [TMR_W-1:0] COL_CYC =
      TMR_W'((CAS_RAW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   // Row phase stretched so that the whole row pulse meets its width
   localparam logic [TMR_W-1:0] ROW_CYC =
      (RAS_CYC > COL_CYC + 1 + RCD_CYC) ? TMR_W'(RAS_CYC - COL_CYC - 1) : RCD_CYC;
   localparam logic [TMR_W-1:0] POWERUP_CYC =
      TMR_W'(T_POWERUP_US * 1000 / CLK_PERIOD_NS);
   // Longest time rounds down
   localparam logic [TMR_W-1:0] REF_INTERVAL_CYC =
      TMR_W'(T_REF_MS * 1000000 / REF_ROWS / CLK_PERIOD_NS);
   localparam int REF_PERIOD_CYC = T_REF_MS * 1000000 / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Request kinds and controller states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      APDC_READ, APDC_WRITE, APDC_ROW_REFRESH, APDC_RSVD
   } apdc_kind_t;

   typedef enum logic [3:0] {
      ST_POWERUP, ST_IDLE, ST_ASET, ST_ROW, ST_ROWONLY, ST_COLSET, ST_COL,
      ST_PAGE, ST_HID_HI, ST_HID_LO, ST_CBR_CAS, ST_CBR_RAS, ST_PRE
   } apdc_state_t;

endpackage

// ---- hw/apdc_timer.sv ----
`timescale 1ns/1ps

// Loadable down counter; done is high while the count stands at zero
module apdc_timer #(
   parameter int W = 12
) (
   input  wire logic         clk,       // System clock
   input  wire logic         sys_rst,   // Synchronous reset, active high
   input  wire logic         load,      // Load strobe
   input  wire logic [W-1:0] load_val,  // Cycles minus one
   output logic              done       // Count has reached zero
);

   logic [W-1:0] count_reg;

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_val;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - W'(1);
      end
   end

   assign done = (count_reg == '0);

endmodule // apdc_timer

// ---- hw/apdc_ctrl.sv ----
`timescale 1ns/1ps

module apdc_ctrl
   import apdc_pkg::*;
#(
   parameter int REF_PERIOD = apdc_pkg::REF_PERIOD_CYC,  // Refresh period in cycles
   parameter int PAGE_MAX   = 64                         // Columns per open row
) (
   input  wire logic                        clk,               // 40 MHz clock
   input  wire logic                        sys_rst,           // Sync reset
   input  wire logic                        req_valid,         // Request offered
   input  wire apdc_pkg::apdc_kind_t        req_kind,          // Read, write, row refresh
   input  wire logic [apdc_pkg::ADDR_W-1:0] req_addr,          // Row high, column low
   input  wire logic [apdc_pkg::DATA_W-1:0] req_wdata,         // Write word
   output logic                             req_ready,         // Request taken when valid
   output logic                             rsp_valid,         // Read word pulse
   output logic [apdc_pkg::DATA_W-1:0]      rsp_rdata,         // Read word
   input  wire logic                        refresh_inhibit,   // Holds off periodic refresh, not the wake-up
   output logic                             init_done,         // Wake-up complete
   output logic                             row_strobe_n,      // Row strobe
   output logic                             column_strobe_n,   // Column strobe, bits 1-8
   output logic                             ninth_bit_column_strobe_n, // Ninth-bit strobe
   output logic                             write_strobe_n,    // Write strobe
   output logic [apdc_pkg::HALF_W-1:0]      multiplexed_address, // Address pins
   output logic [7:0]                       shared_byte_data_o,  // Byte data out
   output logic                             shared_byte_data_oe, // Byte data drive
   input  wire logic [7:0]                  shared_byte_data_i,  // Byte data in
   output logic                             ninth_bit_data_in,   // Ninth bit to device
   input  wire logic                        ninth_bit_data_out   // Ninth bit from device
);
   import apdc_pkg::*;

   apdc_state_t              state_reg, state_next;
   apdc_kind_t               kind_reg;
   logic [ADDR_W-1:0]        addr_reg;
   logic [DATA_W-1:0]        wdata_reg;
   logic                     pend_reg;
   logic                     ref_pend_reg, ref_pend_next;
   logic                     ready_next;
   logic [3:0]               wake_reg;
   logic [STALE_W-1:0]       stale_reg;
   logic [7:0]               burst_reg;
   logic [TMR_W-1:0]         tmr_val;
   logic                     tmr_done, ivl_done, take, same_row, ref_go, stale_hit;
   logic                     pwr_arm_reg;

   assign take      = req_valid && req_ready;
   assign same_row  = (req_addr[ADDR_W-1:HALF_W] == addr_reg[ADDR_W-1:HALF_W]);
   assign ref_go    = ref_pend_reg && !refresh_inhibit;
   assign stale_hit = (stale_reg == STALE_W'(REF_PERIOD));

   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   apdc_timer #(.W(TMR_W)) u_state_tmr (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .load     ((state_next != state_reg) || pwr_arm_reg),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   apdc_timer #(.W(TMR_W)) u_ivl_tmr (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .load     (ivl_done),
      .load_val (REF_INTERVAL_CYC - TMR_W'(1)),
      .done     (ivl_done)
   );

   // Duration of the state being entered
   always_comb begin
      case (state_next)
         ST_POWERUP: tmr_val = POWERUP_CYC - TMR_W'(1);
         ST_ROW:     tmr_val = ROW_CYC - TMR_W'(1);
         ST_ROWONLY: tmr_val = RAS_CYC - TMR_W'(1);
         ST_COL:     tmr_val = COL_CYC - TMR_W'(1);
         ST_HID_HI:  tmr_val = RP_CYC - TMR_W'(1);
         ST_HID_LO:  tmr_val = RAS_CYC - TMR_W'(1);
         ST_CBR_CAS: tmr_val = CSR_CYC - TMR_W'(1);
         ST_CBR_RAS: tmr_val = RAS_CYC - TMR_W'(1);
         ST_PRE:     tmr_val = RP_CYC - TMR_W'(1);
         default:    tmr_val = '0;
      endcase
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_POWERUP: if (tmr_done && !pwr_arm_reg) state_next = ST_CBR_CAS;
         // A taken request goes first, so a refresh that falls due cannot swallow it
         ST_IDLE: begin
            if (take) state_next = ST_ASET;
            else if (!init_done || ref_go) state_next = ST_CBR_CAS;
         end
         ST_ASET:
            state_next = (kind_reg == APDC_ROW_REFRESH) ? ST_ROWONLY : ST_ROW;
         ST_ROW:     if (tmr_done) state_next = ST_COLSET;
         ST_ROWONLY: if (tmr_done) state_next = ST_PRE;
         ST_COLSET:  state_next = ST_COL;
         ST_COL: begin
            if (tmr_done) state_next = ref_go ? ST_HID_HI : ST_PAGE;
         end
         ST_PAGE: begin
            if (take && same_row && req_kind != APDC_ROW_REFRESH) state_next = ST_COLSET;
            else state_next = ST_PRE;
         end
         ST_HID_HI:  if (tmr_done) state_next = ST_HID_LO;
         ST_HID_LO:  if (tmr_done) state_next = ST_PRE;
         ST_CBR_CAS: if (tmr_done) state_next = ST_CBR_RAS;
         ST_CBR_RAS: if (tmr_done) state_next = ST_PRE;
         ST_PRE: begin
            if (tmr_done) begin
               if (!init_done && wake_reg != 4'(WAKE_COUNT)) state_next = ST_CBR_CAS;
               else if (pend_reg) state_next = ST_ASET;
               else state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) state_reg <= ST_POWERUP;
      else         state_reg <= state_next;
   end

   // Loads the power-up pause in the first cycle after reset; the timer reads zero before
   always_ff @(posedge clk) begin
      if (sys_rst) pwr_arm_reg <= 1'b1;
      else         pwr_arm_reg <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Refresh bookkeeping and wake-up
   // ---------------------------------------------------------------
   always_comb begin
      ref_pend_next = ref_pend_reg;
      if (state_next == ST_CBR_CAS || state_next == ST_HID_HI) ref_pend_next = 1'b0;
      if (ivl_done) ref_pend_next = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_pend_reg <= 1'b0;
         stale_reg    <= '0;
         wake_reg     <= '0;
         init_done    <= 1'b0;
      end else begin
         ref_pend_reg <= ref_pend_next;
         if ((state_reg == ST_CBR_RAS || state_reg == ST_HID_LO) && tmr_done) begin
            stale_reg <= '0;
         end else if (!stale_hit) begin
            stale_reg <= stale_reg + STALE_W'(1);
         end
         if (stale_hit) begin
            init_done <= 1'b0;
            wake_reg  <= '0;
         end else if (state_reg == ST_PRE && tmr_done && wake_reg == 4'(WAKE_COUNT)) begin
            init_done <= 1'b1;
         end
         // A row cycle that ends as the watchdog trips still counts towards the wake-up
         if (!init_done && state_reg == ST_CBR_RAS && tmr_done) wake_reg <= wake_reg + 4'd1;
      end
   end

   // ---------------------------------------------------------------
   // Request capture
   // ---------------------------------------------------------------
   always_comb begin
      ready_next = 1'b0;
      if (init_done && !stale_hit && !(ref_pend_next && !refresh_inhibit)) begin
         ready_next = (state_next == ST_IDLE) ||
                      (state_next == ST_PAGE && burst_reg != 8'(PAGE_MAX));
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_ready <= 1'b0;
         kind_reg  <= APDC_READ;
         addr_reg  <= '0;
         wdata_reg <= '0;
         pend_reg  <= 1'b0;
         burst_reg <= '0;
      end else begin
         req_ready <= ready_next;
         if (take) begin
            kind_reg  <= req_kind;
            addr_reg  <= req_addr;
            wdata_reg <= req_wdata;
         end
         pend_reg <= take && state_reg == ST_PAGE && state_next == ST_PRE ? 1'b1 :
                     (state_next == ST_ASET ? 1'b0 : pend_reg);
         if (state_next == ST_ROW) burst_reg <= '0;
         else if (state_next == ST_COL && state_reg != ST_COL) burst_reg <= burst_reg + 8'd1;
      end
   end

   // ---------------------------------------------------------------
   // Pins, registered from the state being entered
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_strobe_n              <= 1'b1;
         column_strobe_n           <= 1'b1;
         ninth_bit_column_strobe_n <= 1'b1;
         write_strobe_n            <= 1'b1;
         multiplexed_address       <= '0;
         shared_byte_data_o        <= '0;
         shared_byte_data_oe       <= 1'b0;
         ninth_bit_data_in         <= 1'b0;
      end else begin
         row_strobe_n <= !(state_next inside {ST_ROW, ST_ROWONLY, ST_COLSET, ST_COL,
                                              ST_PAGE, ST_HID_LO, ST_CBR_RAS});
         column_strobe_n <= !(state_next inside {ST_COL, ST_HID_HI, ST_HID_LO,
                                                 ST_CBR_CAS, ST_CBR_RAS});
         ninth_bit_column_strobe_n <= !(state_next inside {ST_COL, ST_HID_HI, ST_HID_LO,
                                                           ST_CBR_CAS, ST_CBR_RAS});
         // Write strobe falls before the column strobe and stays low through refresh_with_held_column
         // A page hit takes its kind from the new request, not from the previous column
         write_strobe_n <= !(((take ? req_kind : kind_reg) == APDC_WRITE) &&
                            (state_next inside {ST_ROW, ST_COLSET, ST_COL, ST_HID_HI,
                                                ST_HID_LO}));
         shared_byte_data_oe <= ((take ? req_kind : kind_reg) == APDC_WRITE) &&
                                (state_next inside {ST_ROW, ST_COLSET, ST_COL, ST_HID_HI,
                                                    ST_HID_LO});
         shared_byte_data_o <= take ? req_wdata[7:0] : wdata_reg[7:0];
         ninth_bit_data_in  <= take ? req_wdata[8] : wdata_reg[8];
         // Row half before the row strobe falls, column half before the column strobe
         if (state_next inside {ST_ASET, ST_ROW, ST_ROWONLY}) begin
            multiplexed_address <= take ? req_addr[ADDR_W-1:HALF_W]
                                        : addr_reg[ADDR_W-1:HALF_W];
         end else if (state_next == ST_COLSET) begin
            multiplexed_address <= take ? req_addr[HALF_W-1:0] : addr_reg[HALF_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read return, sampled in the last column-low cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= state_reg == ST_COL && tmr_done && kind_reg == APDC_READ;
         if (state_reg == ST_COL && tmr_done && kind_reg == APDC_READ) begin
            rsp_rdata <= {ninth_bit_data_out, shared_byte_data_i};
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_POWERUP_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == ST_POWERUP |-> row_strobe_n && !init_done)
      else $error("row strobe active during power-up pause");
   AST_STALE_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
      stale_hit |=> !init_done && !req_ready)
      else $error("stale refresh did not restart wake-up");
   AST_COL_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(column_strobe_n) && !row_strobe_n |-> multiplexed_address == addr_reg[HALF_W-1:0])
      else $error("column half wrong at column strobe");
   AST_NO_LATE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(write_strobe_n) |-> column_strobe_n)
      else $error("write strobe fell with column strobe low");
   AST_PRECHARGE: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(row_strobe_n) |-> row_strobe_n [*3])
      else $error("row precharge too short");
   AST_NINTH_TRACKS: assert property (@(posedge clk) disable iff (sys_rst)
      ninth_bit_column_strobe_n == column_strobe_n)
      else $error("ninth-bit strobe diverged");
   AST_ROW_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == ST_ROWONLY |-> column_strobe_n && !row_strobe_n)
      else $error("row-only refresh with column strobe low");
   AST_HIDDEN: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == ST_HID_HI |-> row_strobe_n && !column_strobe_n && $stable(write_strobe_n))
      else $error("refresh_with_held_column released column strobe");
   AST_CBR_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(row_strobe_n) && !column_strobe_n |->
         $past(!column_strobe_n) && (shared_byte_data_oe == !write_strobe_n))
      else $error("column strobe not set before row strobe");
   AST_DRIVE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      shared_byte_data_oe |-> !write_strobe_n)
      else $error("data driven outside a write");

endmodule // apdc_ctrl

// ---- tb/apdc_dram_model.sv ----
`timescale 1ns/1ps

// Behavioural memory module facing the controller
module apdc_dram_model #(
   parameter int ACC_NS = 20  // Access from column fall
) (
   input  wire logic       row_strobe_n,              // Row strobe
   input  wire logic       column_strobe_n,           // Column strobe
   input  wire logic       ninth_bit_column_strobe_n, // Ninth-bit strobe
   input  wire logic       write_strobe_n,            // Write strobe
   input  wire logic [9:0] multiplexed_address,       // Address pins
   input  wire logic [7:0] shared_byte_data_o,        // Host byte
   input  wire logic       shared_byte_data_oe,       // Host drives
   input  wire logic       ninth_bit_data_in,         // Host ninth bit
   output logic      [7:0] shared_byte_data_i,        // Resolved byte bus
   output logic            ninth_bit_data_out         // Ninth bit out
);
   logic [8:0] mem [logic [19:0]];  // Sparse store
   logic [9:0] row_reg = 10'h000;   // Latched row
   logic [8:0] q_reg = 9'h000;      // Output word
   logic       drv = 1'b0;          // Outputs driven
   int         ras_cnt = 0;         // Row falls
   int         cbr_cnt = 0;         // Counter refreshes
   int         open_cnt = 0;        // Addressed rows
   int         viol_cnt = 0;        // Breaches seen

   // Row fall: counter refresh when the column is already low
   always @(negedge row_strobe_n) begin
      ras_cnt++;
      if (column_strobe_n === 1'b0) begin
         cbr_cnt++;
      end else begin
         row_reg = multiplexed_address;
         open_cnt++;
      end
   end

   // Column fall in an open row: early write or read
   always @(negedge column_strobe_n) begin
      if (row_strobe_n === 1'b0) begin
         if (ras_cnt < 9 || $time < 100000) viol_cnt++;
         if (write_strobe_n === 1'b0) begin
            if (shared_byte_data_oe !== 1'b1) viol_cnt++;
            mem[{row_reg, multiplexed_address}] =
               {ninth_bit_data_in, shared_byte_data_o};
         end else begin
            if (shared_byte_data_oe === 1'b1) viol_cnt++;
            q_reg = mem.exists({row_reg, multiplexed_address}) ?
                    mem[{row_reg, multiplexed_address}] : 9'h000;
            drv <= #(ACC_NS) 1'b1;
         end
      end
   end

   // Column rise releases the outputs
   always @(posedge column_strobe_n) drv = 1'b0;
   // Write strobe may not fall inside a column cycle
   always @(negedge write_strobe_n)
      #1 if (!row_strobe_n && !column_strobe_n) viol_cnt++;
   // Both column strobes move as one
   always @(column_strobe_n, ninth_bit_column_strobe_n)
      #1 if (column_strobe_n !== ninth_bit_column_strobe_n) viol_cnt++;

   // A released line shows the inverse of the last word
   assign shared_byte_data_i = shared_byte_data_oe ? shared_byte_data_o :
                               (drv ? q_reg[7:0] : ~q_reg[7:0]);
   assign ninth_bit_data_out = drv ? q_reg[8] : ~q_reg[8];
endmodule // apdc_dram_model

// ---- tb/tb_async_page_mode_dram_1mx9.sv ----
`timescale 1ns/1ps

// Self-checking bench for the page-mode memory controller
module tb_async_page_mode_dram_1mx9;
   import apdc_pkg::*;

   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              req_valid = 1'b0;
   apdc_kind_t        req_kind = APDC_READ;
   logic [ADDR_W-1:0] req_addr = 20'h00000;
   logic [DATA_W-1:0] req_wdata = 9'h000;
   logic              inhibit = 1'b0;
   logic              req_ready, rsp_valid, init_done, row_n, col_n, col9_n, wr_n, oe, d9, q9;
   logic [DATA_W-1:0] rsp_rdata;
   logic [9:0]        addr_pins;
   logic [7:0]        byte_o, byte_i;
   logic [8:0]        rq[$];
   logic [9:0]        cols [4] = '{10'h000, 10'h001, 10'h2aa, 10'h3ff};
   logic [8:0]        pat [4] = '{9'h1a5, 9'h05a, 9'h100, 9'h0ff};
   int                err_count = 0;
   int                checks = 0;
   int                hid_wr = 0;

   apdc_ctrl #(.REF_PERIOD(2000)) dut (
      .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_kind(req_kind),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .refresh_inhibit(inhibit),
      .init_done(init_done), .row_strobe_n(row_n), .column_strobe_n(col_n),
      .ninth_bit_column_strobe_n(col9_n), .write_strobe_n(wr_n),
      .multiplexed_address(addr_pins), .shared_byte_data_o(byte_o),
      .shared_byte_data_oe(oe), .shared_byte_data_i(byte_i),
      .ninth_bit_data_in(d9), .ninth_bit_data_out(q9));
   apdc_dram_model mdl (
      .row_strobe_n(row_n), .column_strobe_n(col_n), .ninth_bit_column_strobe_n(col9_n),
      .write_strobe_n(wr_n), .multiplexed_address(addr_pins), .shared_byte_data_o(byte_o),
      .shared_byte_data_oe(oe), .ninth_bit_data_in(d9), .shared_byte_data_i(byte_i),
      .ninth_bit_data_out(q9));

   // Clock and answer capture
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) if (rsp_valid === 1'b1) rq.push_back(rsp_rdata);
   // Row falls with column and write strobes low: a refresh held inside a write
   always @(negedge row_n) if (col_n === 1'b0 && wr_n === 1'b0) hid_wr++;

   // Comparisons and verdict
   task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Request port driving; a request stays up until the edge that takes it
   task automatic send(input apdc_kind_t k, input logic [19:0] a, input logic [8:0] d);
      int n;
      n = 0;
      @(negedge clk);
      req_valid = 1'b1;
      req_kind = k;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk32((n < 2000) ? 32'h1 : 32'h0, 32'h1);
      @(posedge clk);
   endtask
   task automatic idle;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic drain(input int k);
      int n;
      n = 0;
      while (rq.size() < k && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk32(32'(rq.size()), 32'(k));
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_wakeup;
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk32(32'(mdl.cbr_cnt), 32'h8);
      chk32(32'(mdl.open_cnt), 32'h0);
      chk32(($time >= 100000) ? 32'h1 : 32'h0, 32'h1);
   endtask
   task automatic t_page;
      int o;
      o = mdl.open_cnt;
      inhibit = 1'b1;
      for (int i = 0; i < 4; i++) send(APDC_WRITE, {10'h3ff, cols[i]}, pat[i]);
      idle;
      repeat (12) @(negedge clk);
      for (int i = 0; i < 4; i++) send(APDC_READ, {10'h3ff, cols[i]}, 9'h000);
      idle;
      drain(4);
      for (int i = 0; i < 4; i++) chk9(rq.pop_front(), pat[i]);
      chk32(32'(mdl.open_cnt - o), 32'h2);
      inhibit = 1'b0;
   endtask
   task automatic t_rowonly;
      int o;
      o = mdl.open_cnt;
      send(APDC_ROW_REFRESH, {10'h2a5, 10'h000}, 9'h000);
      idle;
      repeat (20) @(negedge clk);
      chk32(32'(mdl.open_cnt - o), 32'h1);
      chk32(32'(mdl.row_reg), 32'h2a5);
      chk32(32'(rq.size()), 32'h0);
   endtask
   task automatic t_restart;
      int c;
      c = mdl.cbr_cnt;
      repeat (1300) @(negedge clk);
      chk32((mdl.cbr_cnt - c >= 2) ? 32'h1 : 32'h0, 32'h1);
      inhibit = 1'b1;
      c = mdl.cbr_cnt;
      repeat (2200) @(negedge clk);
      chk32((mdl.cbr_cnt - c >= 8) ? 32'h1 : 32'h0, 32'h1);
      chk32(32'(init_done), 32'h1);
      c = mdl.cbr_cnt;
      inhibit = 1'b0;
      repeat (700) @(negedge clk);
      chk32((mdl.cbr_cnt - c >= 1) ? 32'h1 : 32'h0, 32'h1);
      send(APDC_READ, {10'h3ff, 10'h3ff}, 9'h000);
      idle;
      drain(1);
      chk9(rq.pop_front(), pat[3]);
   endtask
   task automatic t_hidden;
      inhibit = 1'b1;
      repeat (700) @(negedge clk);
      send(APDC_WRITE, {10'h155, 10'h0aa}, 9'h0c3);
      idle;
      inhibit = 1'b0;
      repeat (20) @(negedge clk);
      chk32(32'(hid_wr), 32'h1);
      send(APDC_READ, {10'h155, 10'h0aa}, 9'h000);
      idle;
      drain(1);
      chk9(rq.pop_front(), 9'h0c3);
   endtask

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      chk32(32'h0, 32'h1);
      report_and_stop;
   end

   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      t_wakeup;
      t_page;
      t_rowonly;
      t_hidden;
      t_restart;
      chk32(32'(mdl.viol_cnt), 32'h0);
      report_and_stop;
   end
endmodule // tb_async_page_mode_dram_1mx9
